/* File: fifo_flag_offset_programming.sv */
// threshold register load and readback for a deep dual-port fifo
// assumes wr_edge and rd_edge are one-cycle sys_clk strobes for port clock edges,
// and that all control inputs come from logic on sys_clk
//
// Behaviour
// - load method strapped at master reset
// - sixteen or seventeen bits, rest ignored
// - serial shift empty lsb to full msb
// - serial load always covers whole bit set
// - no shift while serial enable high
// - pause shifting for memory writes, resume
// - serial load flags valid two edges later
// - x36 parallel writes alternate empty, full
// - x18 parallel takes four pieces, wraps
// - x9 parallel takes six pieces
// - separate write and read pointers
// - master reset clears both pointers
// - partial reset keeps pointer positions
// - load select high redirects to memory
// - parallel flag valid after own word
// - x36 readback alternates empty, full
// - x18 four reads, x9 six reads
// - readback pauses and resumes in place
// - readback overwrites output register
// - readback parallel only, any timing mode
// - memory writes allowed around serial load
`default_nettype none

`include "fifo_offset_consts.svh"

module fifo_flag_offset_programming #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic                       master_reset,
	input  wire logic                       partial_reset,
	input  wire logic                       wr_edge,
	input  wire logic                       rd_edge,
	input  wire fifo_offset_pkg::ctrl_pins_s ctrl,
	input  wire fifo_offset_pkg::bus_width_e in_width,
	input  wire fifo_offset_pkg::bus_width_e out_width,
	input  wire logic [35:0]                data_in_bus,
	output var  logic [35:0]                data_out_bus,
	output logic                            mem_write,
	output logic                            mem_read,
	output var  fifo_offset_pkg::load_mode_e load_mode,
	output var  logic [16:0]                almost_empty_threshold,
	output var  logic [16:0]                almost_full_threshold,
	output logic                            almost_empty_valid,
	output logic                            almost_full_valid
);

	localparam logic [4:0] OFS_BITS = LARGE_VARIANT ? `OFS_BITS_LARGE : `OFS_BITS_SMALL;
	localparam logic [5:0] SER_LAST = {OFS_BITS, 1'b0} - 6'd1;

	// pieces that make up one threshold at the given bus width
	function automatic logic [2:0] pieces_per(input fifo_offset_pkg::bus_width_e w);
		case (w)
			fifo_offset_pkg::BUS_X36: pieces_per = `PIECES_X36;
			fifo_offset_pkg::BUS_X18: pieces_per = `PIECES_X18;
			default:                  pieces_per = `PIECES_X9;
		endcase
	endfunction

	// pointer to {threshold select, piece within threshold}
	function automatic logic [2:0] decode_ptr(input logic [2:0] p,
		input fifo_offset_pkg::bus_width_e w);
		logic [2:0] n;
		logic       sel;
		n   = pieces_per(w);
		sel = (p >= n);
		decode_ptr = {sel, 2'(p - (sel ? n : 3'd0))};
	endfunction

	// next pointer position, wrapping after the full threshold's last piece
	function automatic logic [2:0] advance_ptr(input logic [2:0] p,
		input fifo_offset_pkg::bus_width_e w);
		logic [2:0] len;
		len = 3'({pieces_per(w), 1'b0});
		advance_ptr = (p + 3'd1 == len) ? `PTR_FIRST : 3'(p + 3'd1);
	endfunction

	// true when the decoded piece is the last one of its threshold
	function automatic logic last_piece(input logic [1:0] piece,
		input fifo_offset_pkg::bus_width_e w);
		last_piece = ({1'b0, piece} == pieces_per(w) - 3'd1);
	endfunction

	// merge one bus piece into a threshold; x18 pieces are 16 bits, x9 pieces 8, the last piece only the top bit
	function automatic logic [16:0] merge_piece(input logic [16:0] old,
		input logic [35:0] d, input fifo_offset_pkg::bus_width_e w, input logic [1:0] piece);
		logic [16:0] v;
		v = old;
		case (w)
			fifo_offset_pkg::BUS_X36: v = d[16:0];
			fifo_offset_pkg::BUS_X18:
				if (piece == 2'd0)
					v = {old[16], d[15:0]};
				else
					v = {d[0], old[15:0]};
			default:
				if (piece == 2'd0)
					v = {old[16:8], d[7:0]};
				else if (piece == 2'd1)
					v = {old[16], d[7:0], old[7:0]};
				else
					v = {d[0], old[15:0]};
		endcase
		// top bit is ignored in the small variant
		if (!LARGE_VARIANT)
			v[16] = 1'b0;
		merge_piece = v;
	endfunction

	// one piece of a threshold placed in the low bits of the output bus
	function automatic logic [35:0] extract_piece(input logic [16:0] val,
		input fifo_offset_pkg::bus_width_e w, input logic [1:0] piece);
		logic [35:0] q;
		q = `DOUT_RESET;
		case (w)
			fifo_offset_pkg::BUS_X36: q[16:0] = val;
			fifo_offset_pkg::BUS_X18:
				if (piece == 2'd0)
					q[15:0] = val[15:0];
				else
					q[0] = val[16];
			default:
				if (piece == 2'd0)
					q[7:0] = val[7:0];
				else if (piece == 2'd1)
					q[7:0] = val[15:8];
				else
					q[0] = val[16];
		endcase
		extract_piece = q;
	endfunction

	fifo_offset_pkg::bus_width_e in_mode;
	fifo_offset_pkg::bus_width_e out_mode;
	logic [2:0]  wr_ptr;
	logic [2:0]  rd_ptr;
	logic [5:0]  ser_cnt;
	logic [2:0]  wr_dec;
	logic [2:0]  rd_dec;
	logic        resets_idle;
	logic        ser_shift;
	logic        par_write;
	logic        ofs_read;
	logic        ser_first;
	logic        ser_last;
	logic        empty_clear;
	logic        empty_start;
	logic        full_clear;
	logic        full_start;
	logic [35:0] read_piece;

	// operations on port clock edges; resets hold all of them off
	assign resets_idle = !master_reset && !partial_reset;
	assign ser_shift = wr_edge && resets_idle && load_mode == fifo_offset_pkg::LOAD_SERIAL
		&& !ctrl.load_sel_n && !ctrl.serial_shift_en_n;
	assign par_write = wr_edge && resets_idle && load_mode == fifo_offset_pkg::LOAD_PARALLEL
		&& !ctrl.load_sel_n && !ctrl.write_en_n;
	assign ofs_read = rd_edge && resets_idle && !ctrl.load_sel_n && !ctrl.read_en_n;

	assign mem_write = wr_edge && resets_idle && ctrl.load_sel_n && !ctrl.write_en_n;
	assign mem_read  = rd_edge && resets_idle && ctrl.load_sel_n && !ctrl.read_en_n;

	assign wr_dec     = decode_ptr(wr_ptr, in_mode);
	assign rd_dec     = decode_ptr(rd_ptr, out_mode);
	assign ser_first  = ser_shift && ser_cnt == `SER_FIRST;
	assign ser_last   = ser_shift && ser_cnt == SER_LAST;
	assign read_piece = extract_piece(rd_dec[2] ? almost_full_threshold : almost_empty_threshold,
		out_mode, rd_dec[1:0]);

	// straps are caught by a clocked process while master reset is held
	// load method strap
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			load_mode <= fifo_offset_pkg::LOAD_PARALLEL;
			in_mode   <= fifo_offset_pkg::BUS_X36;
			out_mode  <= fifo_offset_pkg::BUS_X36;
		end
		else if (master_reset)
		begin
			load_mode <= ctrl.load_sel_n ? fifo_offset_pkg::LOAD_SERIAL
				: fifo_offset_pkg::LOAD_PARALLEL;
			in_mode   <= in_width;
			out_mode  <= out_width;
		end
	end

	// serial bit position; a pause simply leaves it where it stands
	// resume at next bit
	always_ff @(posedge sys_clk)
	begin
		if (rst || master_reset)
			ser_cnt <= `SER_FIRST;
		else if (ser_last)
			ser_cnt <= `SER_FIRST;
		else if (ser_shift)
			ser_cnt <= 6'(ser_cnt + 6'd1);
	end

	// parallel write pointer; partial reset is deliberately not a term here
	// independent write pointer
	always_ff @(posedge sys_clk)
	begin
		if (rst || master_reset)
			wr_ptr <= `PTR_FIRST;
		else if (par_write)
			wr_ptr <= advance_ptr(wr_ptr, in_mode);
	end

	// readback pointer, same reset treatment as the write pointer
	// resume where stopped
	always_ff @(posedge sys_clk)
	begin
		if (rst || master_reset)
			rd_ptr <= `PTR_FIRST;
		else if (ofs_read)
			rd_ptr <= advance_ptr(rd_ptr, out_mode);
	end

	// threshold registers; serial and parallel never both fire since the mode is fixed
	// whole bit set shifted
	always_ff @(posedge sys_clk)
	begin
		if (rst || master_reset)
		begin
			almost_empty_threshold <= `DEFAULT_EMPTY;
			almost_full_threshold  <= `DEFAULT_FULL;
		end
		else if (ser_shift)
		begin
			if (ser_cnt < {1'b0, OFS_BITS})
				almost_empty_threshold[ser_cnt[4:0]] <= ctrl.serial_in;
			else
				almost_full_threshold[5'(ser_cnt - {1'b0, OFS_BITS})] <= ctrl.serial_in;
		end
		else if (par_write)
		begin
			if (wr_dec[2])
				almost_full_threshold <= merge_piece(almost_full_threshold, data_in_bus,
					in_mode, wr_dec[1:0]);
			else
				almost_empty_threshold <= merge_piece(almost_empty_threshold, data_in_bus,
					in_mode, wr_dec[1:0]);
		end
	end

	// output register; a readback replaces whatever word was there
	// readback order
	always_ff @(posedge sys_clk)
	begin
		if (rst || master_reset || partial_reset)
			data_out_bus <= `DOUT_RESET;
		else if (ofs_read)
			data_out_bus <= read_piece;
	end

	// flag validity events; serial invalidates both, parallel only the touched one
	// serial flags invalid
	assign empty_clear = ser_first || (par_write && !wr_dec[2]);
	assign empty_start = ser_last || (par_write && !wr_dec[2] && last_piece(wr_dec[1:0], in_mode));
	assign full_clear  = ser_first || (par_write && wr_dec[2]);
	assign full_start  = ser_last || (par_write && wr_dec[2] && last_piece(wr_dec[1:0], in_mode));

	// almost-empty counts read edges, almost-full counts write edges
	flag_valid_tracker empty_track (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.preset     (master_reset),
		.clear      (empty_clear),
		.start      (empty_start),
		.edge_pulse (rd_edge),
		.valid      (almost_empty_valid)
	);

	flag_valid_tracker full_track (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.preset     (master_reset),
		.clear      (full_clear),
		.start      (full_start),
		.edge_pulse (wr_edge),
		.valid      (almost_full_valid)
	);

	// checks against the behaviour above
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_mode_strap: assert property (
		master_reset |=> load_mode == ($past(ctrl.load_sel_n) ? fifo_offset_pkg::LOAD_SERIAL
			: fifo_offset_pkg::LOAD_PARALLEL))
		else $error("load method not taken from strap");

	chk_ptr_master: assert property (
		master_reset |=> wr_ptr == `PTR_FIRST && rd_ptr == `PTR_FIRST && ser_cnt == `SER_FIRST)
		else $error("pointers not cleared by master reset");

	chk_ptr_partial: assert property (
		partial_reset && !master_reset |=> $stable(wr_ptr) && $stable(rd_ptr))
		else $error("partial reset moved a pointer");

	chk_shift_blocked: assert property (
		load_mode == fifo_offset_pkg::LOAD_SERIAL && wr_edge && !ctrl.load_sel_n
		&& ctrl.serial_shift_en_n && !master_reset
		|=> $stable(ser_cnt) && $stable(almost_empty_threshold) && $stable(almost_full_threshold))
		else $error("serial bit taken with shift enable high");

	chk_serial_wrap: assert property (
		ser_shift && ser_cnt == SER_LAST |=> ser_cnt == `SER_FIRST)
		else $error("serial counter did not wrap");

	chk_wr_advance: assert property (
		par_write |=> wr_ptr == advance_ptr($past(wr_ptr), in_mode))
		else $error("write pointer did not advance");

	chk_read_data: assert property (
		ofs_read |=> data_out_bus == $past(read_piece))
		else $error("readback word not on output");

	chk_read_pause: assert property (
		rd_edge && (ctrl.load_sel_n || ctrl.read_en_n) && !master_reset |=> $stable(rd_ptr))
		else $error("read pointer moved while paused");

	chk_serial_invalid: assert property (
		ser_first && !ser_last |=> !almost_empty_valid && !almost_full_valid)
		else $error("flag valid during serial load");

	chk_full_latency: assert property (
		full_start ##1 (!wr_edge && !full_clear && !master_reset) [*2]
		|-> !almost_full_valid)
		else $error("full flag valid before two write edges");

	chk_small_mask: assert property (
		!LARGE_VARIANT |-> !almost_empty_threshold[16] && !almost_full_threshold[16])
		else $error("ignored threshold bit stored");

	cov_serial_done: cover property (ser_last);
	cov_par_wrap: cover property (par_write && advance_ptr(wr_ptr, in_mode) == `PTR_FIRST);
	cov_read_resume: cover property (ofs_read ##[1:8] (rd_edge && ctrl.load_sel_n) ##[1:8] ofs_read);
	cov_valid_back: cover property ($rose(almost_empty_valid));

endmodule // fifo_flag_offset_programming

`default_nettype wire

/* File: fifo_offset_consts.svh */
// offset programming constants: register widths, sequence lengths, reset values
// assumes inclusion by bare name from the design modules
`ifndef FIFO_OFFSET_CONSTS_SVH
`define FIFO_OFFSET_CONSTS_SVH

// significant bits of one threshold register, per depth variant
`define OFS_BITS_SMALL   5'd16
`define OFS_BITS_LARGE   5'd17

// register pieces per threshold for each bus width
`define PIECES_X36       3'd1
`define PIECES_X18       3'd2
`define PIECES_X9        3'd3

// pointer and serial counter start positions
`define PTR_FIRST        3'd0
`define SER_FIRST        6'h00

// threshold values in force after master reset
`define DEFAULT_EMPTY    17'h0_007f
`define DEFAULT_FULL     17'h0_007f

// clock edges from completed load to valid flag
`define VALID_EDGES      2'd2

// output register value after master or partial reset
`define DOUT_RESET       36'h0_0000_0000

`endif

/* File: fifo_offset_pkg.sv */
// shared types for the offset programming logic
// assumes fifo_offset_consts.svh is on the include path
`default_nettype none

package fifo_offset_pkg;

	// bus width selected at master reset
	typedef enum logic [1:0] {BUS_X36, BUS_X18, BUS_X9} bus_width_e;

	// offset loading method selected at master reset
	typedef enum logic {LOAD_PARALLEL, LOAD_SERIAL} load_mode_e;

	// control pins from the external controller, all active low except serial_in
	typedef struct packed {
		logic load_sel_n;
		logic write_en_n;
		logic read_en_n;
		logic serial_shift_en_n;
		logic serial_in;
	} ctrl_pins_s;

endpackage

`default_nettype wire

/* File: flag_valid_tracker.sv */
// tracks validity of one programmable flag after its threshold is loaded
// assumes edge_pulse is a one-cycle strobe on sys_clk marking a port clock edge
`default_nettype none

`include "fifo_offset_consts.svh"

module flag_valid_tracker (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic preset,
	input  wire logic clear,
	input  wire logic start,
	input  wire logic edge_pulse,
	output var  logic valid
);

	logic       armed;
	logic [1:0] edge_cnt;

	// start wins over clear so the last load piece always arms the count;
	// the edge that loads the piece is not one of the counted edges
	always_ff @(posedge sys_clk)
	begin
		if (rst || preset)
		begin
			valid    <= 1'b1;
			armed    <= 1'b0;
			edge_cnt <= 2'd0;
		end
		else if (start)
		begin
			valid    <= 1'b0;
			armed    <= 1'b1;
			edge_cnt <= 2'd0;
		end
		else if (clear)
		begin
			valid    <= 1'b0;
			armed    <= 1'b0;
			edge_cnt <= 2'd0;
		end
		else if (armed && edge_pulse)
		begin
			if (edge_cnt == `VALID_EDGES - 2'd1)
			begin
				valid    <= 1'b1;
				armed    <= 1'b0;
				edge_cnt <= 2'd0;
			end
			else
				edge_cnt <= 2'(edge_cnt + 2'd1);
		end
	end

endmodule // flag_valid_tracker

`default_nettype wire

/* File: offset_ctrl_model.sv */
// controller model: drives the offset programming pins and port clock edges
// assumes sys_clk is the bench clock; each request is a single-cycle edge strobe
`default_nettype none

module offset_ctrl_model (
	input  wire logic                        sys_clk,
	output var  logic                        wr_edge,
	output var  logic                        rd_edge,
	output var  fifo_offset_pkg::ctrl_pins_s ctrl,
	output var  logic [35:0]                 data_in_bus
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: no edges, every control inactive
	initial
	begin
		wr_edge     = 1'b0;
		rd_edge     = 1'b0;
		ctrl        = 5'h1e;
		data_in_bus = 36'h0_0000_0000;
	end

	// load select level held while master reset samples the straps
	task automatic strap(input logic ld_n);
		@(negedge sys_clk);
		ctrl <= {ld_n, 4'he};
	endtask

	task automatic pulse(input logic wr, input logic [4:0] pins, input logic [35:0] d);
		@(negedge sys_clk);
		ctrl        <= pins;
		data_in_bus <= d;
		wr_edge     <= wr;
		rd_edge     <= ~wr;
		@(negedge sys_clk);
		wr_edge     <= 1'b0;
		rd_edge     <= 1'b0;
		// released controls go high, data and serial_in show the inverse so stale data is never taken twice
		ctrl        <= {4'hf, ~pins[0]};
		data_in_bus <= ~d;
	endtask
endmodule // offset_ctrl_model

`default_nettype wire

/* File: fifo_flag_offset_programming_tb.sv */
// self-checking bench for threshold register load and readback
// assumes the controller model drives every control pin and port edge strobe
`default_nettype none

module fifo_flag_offset_programming_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// pin sets: load_sel_n, write_en_n, read_en_n, serial_shift_en_n, serial_in
	localparam logic [4:0] pw   = 5'h06;
	localparam logic [4:0] pr   = 5'h0a;
	localparam logic [4:0] ps   = 5'h0c;
	localparam logic [4:0] mw   = 5'h16;
	localparam logic [4:0] mr   = 5'h1a;
	localparam logic [4:0] hold = 5'h0e;
	localparam logic [4:0] idle = 5'h1e;

	logic                        sys_clk;
	logic                        rst;
	logic                        master_reset;
	logic                        partial_reset;
	logic                        wr_edge;
	logic                        rd_edge;
	fifo_offset_pkg::ctrl_pins_s ctrl;
	fifo_offset_pkg::bus_width_e width;
	logic [35:0]                 data_in_bus;
	logic [35:0]                 data_out_bus;
	logic                        mem_write;
	logic                        mem_read;
	fifo_offset_pkg::load_mode_e load_mode;
	logic [16:0]                 ae_thr;
	logic [16:0]                 af_thr;
	logic                        ae_ok;
	logic                        af_ok;
	int                          bad_count;
	int                          checks;
	int                          cycles;
	int                          n_mw;
	int                          n_mr;

	offset_ctrl_model ctl (
		.sys_clk     (sys_clk),
		.wr_edge     (wr_edge),
		.rd_edge     (rd_edge),
		.ctrl        (ctrl),
		.data_in_bus (data_in_bus)
	);

	fifo_flag_offset_programming dut (
		.sys_clk                (sys_clk),
		.rst                    (rst),
		.master_reset           (master_reset),
		.partial_reset          (partial_reset),
		.wr_edge                (wr_edge),
		.rd_edge                (rd_edge),
		.ctrl                   (ctrl),
		.in_width               (width),
		.out_width              (width),
		.data_in_bus            (data_in_bus),
		.data_out_bus           (data_out_bus),
		.mem_write              (mem_write),
		.mem_read               (mem_read),
		.load_mode              (load_mode),
		.almost_empty_threshold (ae_thr),
		.almost_full_threshold  (af_thr),
		.almost_empty_valid     (ae_ok),
		.almost_full_valid      (af_ok)
	);

	// 125 MHz clock
	always #4 sys_clk = ~sys_clk;

	// memory strobe counts and a hang limit far above the expected run length
	always @(posedge sys_clk)
	begin
		cycles++;
		if (mem_write === 1'b1)
			n_mw++;
		if (mem_read === 1'b1)
			n_mr++;
		if (cycles == 4000)
		begin
			bad_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp_val(input logic [35:0] got, input logic [35:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic wr_op(input logic [4:0] pins, input logic [35:0] d);
		ctl.pulse(1'b1, pins, d);
	endtask

	task automatic rd_op(input logic [4:0] pins);
		ctl.pulse(1'b0, pins, 36'h0_0000_0000);
	endtask

	task automatic mreset(input fifo_offset_pkg::bus_width_e w, input logic ld_n);
		ctl.strap(ld_n);
		width        <= w;
		master_reset <= 1'b1;
		repeat (2) @(negedge sys_clk);
		master_reset <= 1'b0;
	endtask

	// piece i of a threshold as carried on a bus split into n pieces
	function automatic logic [35:0] piece(input logic [16:0] v, input int n, input int i);
		if (n == 1)
			return 36'(v);
		if (i == n - 1)
			return 36'(v[16]);
		return (n == 2) ? 36'(v[15:0]) : 36'(v[8*i +: 8]);
	endfunction

	// flags stay invalid after one edge of each port, valid after two
	task automatic settle();
		wr_op(idle, 36'h0_0000_0000);
		rd_op(idle);
		cmp_bit(af_ok, 1'b0, "full flag early");
		cmp_bit(ae_ok, 1'b0, "empty flag early");
		wr_op(idle, 36'h0_0000_0000);
		rd_op(idle);
		@(negedge sys_clk);
		cmp_bit(af_ok, 1'b1, "full flag late");
		cmp_bit(ae_ok, 1'b1, "empty flag late");
	endtask

	task automatic read_all(input logic [16:0] e, input logic [16:0] f, input int n);
		for (int i = 0; i < 2 * n; i++)
		begin
			rd_op(pr);
			cmp_val(data_out_bus, piece(i < n ? e : f, n, i % n), "readback piece");
		end
	endtask

	task automatic para_round(input fifo_offset_pkg::bus_width_e bw, input int n,
		input logic [16:0] e, input logic [16:0] f);
		logic [16:0] ew;
		mreset(bw, 1'b0);
		cmp_bit(load_mode, fifo_offset_pkg::LOAD_PARALLEL, "parallel mode");
		for (int i = 0; i < 2 * n; i++)
		begin
			wr_op(pw, piece(i < n ? e : f, n, i % n) | 36'hf_0000_0000);
			if (i == 0)
			begin
				cmp_bit(ae_ok, 1'b0, "empty flag during load");
				wr_op(mw, 36'h0_0000_0777);
				wr_op(hold, 36'h0_0000_0000);
			end
		end
		cmp_val(36'(ae_thr), 36'(e), "empty threshold");
		cmp_val(36'(af_thr), 36'(f), "full threshold");
		settle();
		read_all(e, f, n);
		ew = e;
		if (n == 1)
			ew = 17'h0_0055;
		else if (n == 2)
			ew[15:0] = 16'h0055;
		else
			ew[7:0] = 8'h55;
		wr_op(pw, 36'h0_0000_0055);
		cmp_val(36'(ae_thr), 36'(ew), "write wrap");
		rd_op(pr);
		cmp_val(data_out_bus, piece(ew, n, 0), "readback wrap");
		rd_op(mr);
		@(negedge sys_clk);
		partial_reset <= 1'b1;
		@(negedge sys_clk);
		partial_reset <= 1'b0;
		cmp_val(data_out_bus, 36'h0_0000_0000, "output after partial reset");
		rd_op(pr);
		cmp_val(data_out_bus, (n == 1) ? 36'(f) : piece(ew, n, 1), "readback resume");
	endtask

	task automatic serial_round(input logic [16:0] e, input logic [16:0] f, input bit pause);
		logic [33:0] s;
		s = {f, e};
		for (int k = 0; k < 34; k++)
		begin
			if (pause && k == 10)
			begin
				wr_op(hold | {4'h0, ~s[10]}, 36'h0_0000_0000);
				wr_op(mw, 36'h0_0000_0000);
			end
			wr_op(ps | {4'h0, s[k]}, 36'h0_0000_0000);
			if (k == 1)
				cmp_bit(af_ok, 1'b0, "full flag during shift");
		end
		cmp_val(36'(ae_thr), 36'(e), "serial empty threshold");
		cmp_val(36'(af_thr), 36'(f), "serial full threshold");
		settle();
		read_all(e, f, 1);
		wr_op(pw, 36'h0_0000_0001);
		cmp_val(36'(ae_thr), 36'(e), "parallel write in serial mode");
	endtask

	// main sequence: defaults, three parallel widths, two serial loads
	initial
	begin
		sys_clk       = 1'b0;
		rst           = 1'b1;
		master_reset  = 1'b0;
		partial_reset = 1'b0;
		width         = fifo_offset_pkg::BUS_X36;
		bad_count     = 0;
		checks        = 0;
		cycles        = 0;
		n_mw          = 0;
		n_mr          = 0;
		repeat (12) @(negedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		cmp_val(36'(ae_thr), 36'h0_0000_007f, "empty default");
		cmp_val(36'(af_thr), 36'h0_0000_007f, "full default");
		cmp_val(data_out_bus, 36'h0_0000_0000, "output default");
		cmp_bit(ae_ok, 1'b1, "empty flag default");
		para_round(fifo_offset_pkg::BUS_X36, 1, 17'h1_2345, 17'h0_0abc);
		para_round(fifo_offset_pkg::BUS_X18, 2, 17'h1_beef, 17'h0_0123);
		para_round(fifo_offset_pkg::BUS_X9, 3, 17'h1_1234, 17'h0_5678);
		mreset(fifo_offset_pkg::BUS_X36, 1'b1);
		cmp_bit(load_mode, fifo_offset_pkg::LOAD_SERIAL, "serial mode");
		serial_round(17'h0_a5c3, 17'h1_3c5a, 1'b1);
		serial_round(17'h1_0f0f, 17'h0_f0f1, 1'b0);
		cmp_val(36'(n_mw), 36'h0_0000_0004, "memory writes");
		cmp_val(36'(n_mr), 36'h0_0000_0003, "memory reads");
		complete_run();
	end
endmodule // fifo_flag_offset_programming_tb

`default_nettype wire
